//--- brtc_pkg.sv
package brtc_pkg;

    // ---------------------------------------------------------------
    // Register offsets
    // ---------------------------------------------------------------
    localparam logic [7:0] ADDR_CONTROL = 8'h5F;
    localparam logic [7:0] ADDR_BOOT = 8'hDC;
    localparam logic [7:0] ADDR_TARGET = 8'hDE;

    // ---------------------------------------------------------------
    // Reset values and field positions
    // ---------------------------------------------------------------
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] TARGET_RESET = 8'h00;
    localparam logic [7:0] TARGET_FIELD_DEFAULT = 8'hDD;
    localparam logic [7:0] CONTROL_MASK = 8'h13;
    localparam int SERIAL_VOLTAGE_ID_CONTROL_BIT = 4;
    localparam int SEL_BIT = 1;
    localparam int EN_BIT = 0;
    localparam int SLEEP_OFF_BIT = 1;
    localparam logic [7:0] TARGET_ZERO = 8'h00;
    localparam logic [7:0] MAX_LIMIT_RESET = 8'hD2;

    // ---------------------------------------------------------------
    // Register file state
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        BRTC_IDLE = 2'b00,
        BRTC_LOAD = 2'b01,
        BRTC_RUN = 2'b11
    } brtc_state_t;

endpackage

//--- brtc_regs_if.sv
interface brtc_regs_if;
    logic [7:0] control;
    logic [7:0] target;
    logic [7:0] max_limit;
    logic [7:0] sleep_reg;
    logic seq_on;
    logic rail_on;
    logic [7:0] applied_code;
    modport ctrl (input control, target, max_limit, sleep_reg, seq_on, output rail_on, applied_code);
    modport regs (output control, target, max_limit, sleep_reg, seq_on, input rail_on, applied_code);
endinterface

//--- brtc_rail_ctrl.sv
module brtc_rail_ctrl (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Register side
    brtc_regs_if.ctrl rif
);

    logic on_d;
    logic [7:0] code_d;

    // ---------------------------------------------------------------
    // On/off source and voltage code
    // ---------------------------------------------------------------
    always_comb begin
        code_d = (rif.target > rif.max_limit) ? rif.max_limit : rif.target;
        if (rif.control[brtc_pkg::SEL_BIT]) begin
            on_d = rif.control[brtc_pkg::EN_BIT];
        end else begin
            on_d = rif.seq_on;
        end
        if (rif.control[brtc_pkg::SERIAL_VOLTAGE_ID_CONTROL_BIT] && rif.target == brtc_pkg::TARGET_ZERO
                && rif.sleep_reg[brtc_pkg::SLEEP_OFF_BIT]) begin
            on_d = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rif.rail_on <= 1'b0;
            rif.applied_code <= 8'h00;
        end else begin
            rif.rail_on <= on_d;
            rif.applied_code <= code_d;
        end
    end

endmodule

//--- brtc_top.sv
// Notes on behaviour
// - Boot code register at 0xDC, factory loaded.
// - Boot bit 0 follows nonzero of bits 7:1.
// - Target code register at 0xDE, read/write.
// - Control bit 4 enables serial voltage control.
// - Bit 1 picks sequencer or bit 0 on/off.
// - Control resets zero; reserved bits read zero.
// - Serial mode, code zero, sleep bit: off.
// - Target code capped by max voltage limit.
module brtc_top (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Register port from host interface logic
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata_q,
    output logic reg_hit_q,
    // Factory settings and neighbouring registers
    input wire logic [7:0] otp_boot_code,
    input wire logic [7:0] max_voltage_limit,
    input wire logic [7:0] sleep_behaviour_register,
    input wire logic seq_on,
    // Rail outputs
    output logic rail_on_q,
    output logic serial_voltage_id_control_q,
    output logic [7:0] target_voltage_code_q,
    output logic [7:0] boot_voltage_code_q
);

    brtc_pkg::brtc_state_t state_q;
    logic [7:0] control_q;
    logic [7:0] target_q;
    logic [7:0] boot_q;
    brtc_regs_if rif();

    function automatic logic [7:0] fix_boot(input logic [7:0] v);
        fix_boot = {v[7:1], |v[7:1]};
    endfunction

    // ---------------------------------------------------------------
    // Factory load after reset
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_q <= brtc_pkg::BRTC_IDLE;
        end else begin
            unique case (state_q)
                brtc_pkg::BRTC_IDLE: state_q <= brtc_pkg::BRTC_LOAD;
                brtc_pkg::BRTC_LOAD: state_q <= brtc_pkg::BRTC_RUN;
                brtc_pkg::BRTC_RUN: state_q <= brtc_pkg::BRTC_RUN;
                default: state_q <= brtc_pkg::BRTC_IDLE;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            boot_q <= 8'h00;
        end else if (state_q == brtc_pkg::BRTC_LOAD) begin
            boot_q <= fix_boot(otp_boot_code);
        end else if (reg_wr && reg_addr == brtc_pkg::ADDR_BOOT) begin
            boot_q <= fix_boot(reg_wdata);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            target_q <= brtc_pkg::TARGET_RESET;
        end else if (reg_wr && reg_addr == brtc_pkg::ADDR_TARGET) begin
            target_q <= reg_wdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            control_q <= brtc_pkg::CONTROL_RESET;
        end else if (reg_wr && reg_addr == brtc_pkg::ADDR_CONTROL) begin
            control_q <= reg_wdata & brtc_pkg::CONTROL_MASK;
        end
    end

    // ---------------------------------------------------------------
    // Read port
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            reg_rdata_q <= 8'h00;
            reg_hit_q <= 1'b0;
        end else begin
            reg_hit_q <= 1'b0;
            reg_rdata_q <= 8'h00;
            if (reg_rd) begin
                unique case (reg_addr)
                    brtc_pkg::ADDR_CONTROL: begin
                        reg_rdata_q <= control_q;
                        reg_hit_q <= 1'b1;
                    end
                    brtc_pkg::ADDR_BOOT: begin
                        reg_rdata_q <= boot_q;
                        reg_hit_q <= 1'b1;
                    end
                    brtc_pkg::ADDR_TARGET: begin
                        reg_rdata_q <= target_q;
                        reg_hit_q <= 1'b1;
                    end
                    default: reg_rdata_q <= 8'h00;
                endcase
            end
        end
    end

    // ---------------------------------------------------------------
    // Rail control
    // ---------------------------------------------------------------
    assign rif.control = control_q;
    assign rif.target = target_q;
    assign rif.max_limit = max_voltage_limit;
    assign rif.sleep_reg = sleep_behaviour_register;
    assign rif.seq_on = seq_on;

    brtc_rail_ctrl u_ctrl (
        .sys_clk(sys_clk),
        .rst(rst),
        .rif(rif)
    );

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rail_on_q <= 1'b0;
            serial_voltage_id_control_q <= 1'b0;
            target_voltage_code_q <= 8'h00;
            boot_voltage_code_q <= 8'h00;
        end else begin
            rail_on_q <= rif.rail_on;
            serial_voltage_id_control_q <= control_q[brtc_pkg::SERIAL_VOLTAGE_ID_CONTROL_BIT];
            target_voltage_code_q <= rif.applied_code;
            boot_voltage_code_q <= boot_q;
        end
    end

endmodule

//--- brtc_monitor.sv
module brtc_monitor (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_hit_q,
    // Rail side
    input wire logic [7:0] otp_boot_code,
    input wire logic [7:0] max_voltage_limit,
    input wire logic [7:0] sleep_behaviour_register,
    input wire logic seq_on,
    input wire logic rail_on_q,
    input wire logic serial_voltage_id_control_q,
    input wire logic [7:0] target_voltage_code_q,
    input wire logic [7:0] boot_voltage_code_q
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic hit_addr;
    logic ctrl_wr;
    assign hit_addr = reg_addr inside {8'h5F, 8'hDC, 8'hDE};
    // Control writes that leave serial control off, so code zero cannot mask the rail
    assign ctrl_wr = reg_wr && reg_addr == 8'h5F && !reg_wdata[4];
    sequence manual_wr;
        ctrl_wr && reg_wdata[1];
    endsequence
    sequence seq_wr_hold;
        ctrl_wr && !reg_wdata[1] ##1 $stable(seq_on) [*3];
    endsequence
    property serial_voltage_id_control_follow;
        (reg_wr && reg_addr == 8'h5F) |-> ##2 serial_voltage_id_control_q == $past(reg_wdata[4], 2);
    endproperty
    property manual_rail;
        manual_wr |-> ##3 rail_on_q == $past(reg_wdata[0], 3);
    endproperty
    a_mapped_hit: assert property (reg_rd && hit_addr |=> reg_hit_q) else $error("mapped read unanswered");
    a_boot_load: assert property ($fell(rst) |->
        ##3 boot_voltage_code_q == {otp_boot_code[7:1], |otp_boot_code[7:1]}) else $error("boot code not loaded");
    a_boot_bit0: assert property (boot_voltage_code_q[0] == |boot_voltage_code_q[7:1])
        else $error("boot bit 0 wrong");
    a_serial_voltage_id_control_follow: assert property (serial_voltage_id_control_follow) else $error("serial control bit lost");
    a_manual_rail: assert property (manual_rail) else $error("rail ignores enable bit");
    a_seq_rail: assert property (seq_wr_hold |-> rail_on_q == seq_on) else $error("rail ignores sequencer");
    a_zero_off: assert property (
        (serial_voltage_id_control_q && target_voltage_code_q == 8'h00 && sleep_behaviour_register[1]) [*3]
        |-> !rail_on_q) else $error("code zero left rail on");
    a_code_clamp: assert property ($stable(max_voltage_limit) [*3] |->
        target_voltage_code_q <= max_voltage_limit) else $error("code above limit");
endmodule
bind brtc_top brtc_monitor mon (.*);

//--- brtc_host.sv
module brtc_host (
    // Clock
    input wire logic sys_clk,
    // Register strobes
    output logic reg_wr = 1'b0,
    output logic reg_rd = 1'b0,
    output logic [7:0] reg_addr = 8'h00,
    output logic [7:0] reg_wdata = 8'h00
);
    timeunit 1ns;
    timeprecision 1ps;
    // Strobe held over one sampling edge; address and data scrambled once it has passed
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = w;
        reg_rd = !w;
        @(negedge sys_clk);
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
endmodule

//--- tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic reg_wr, reg_rd, reg_hit_q, seq_on, rail_on_q, serial_voltage_id_control_q;
    logic [7:0] reg_addr, reg_wdata, reg_rdata_q, otp_boot_code, max_voltage_limit, sleep_behaviour_register;
    logic [7:0] target_voltage_code_q, boot_voltage_code_q;
    int n_fail = 0;
    int n_tests = 0;
    int cyc = 0;
    brtc_host host (.*);
    brtc_top dut (.*);
    always #20 sys_clk = ~sys_clk;
    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 1000) begin
            n_fail++;
            give_verdict();
        end
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        host.access(1'b0, a, 8'h00);
        chk(reg_rdata_q, exp);
        chk({7'h00, reg_hit_q}, {7'h00, (a inside {8'h5F, 8'hDC, 8'hDE})});
    endtask
    task automatic rail(input logic e);
        repeat (3) @(negedge sys_clk);
        chk({7'h00, rail_on_q}, {7'h00, e});
    endtask
    initial begin
        otp_boot_code = 8'h40;
        max_voltage_limit = 8'hD2;
        sleep_behaviour_register = 8'h02;
        seq_on = 1'b0;
        repeat (3) @(negedge sys_clk);
        rst = 1'b0;
        repeat (2) @(negedge sys_clk);
        rd(8'hDC, 8'h41);
        chk(boot_voltage_code_q, 8'h41);
        rd(8'h5F, 8'h00);
        rd(8'hDE, 8'h00);
        rd(8'h60, 8'h00);
        host.access(1'b1, 8'hDC, 8'h01);
        rd(8'hDC, 8'h00);
        chk(boot_voltage_code_q, 8'h00);
        host.access(1'b1, 8'h60, 8'hFF);
        host.access(1'b1, 8'h5F, 8'hFF);
        rd(8'h5F, 8'h13);
        chk({7'h00, serial_voltage_id_control_q}, 8'h01);
        host.access(1'b1, 8'hDE, 8'hD3);
        rd(8'hDE, 8'hD3);
        chk(target_voltage_code_q, 8'hD2);
        max_voltage_limit = 8'hD3;
        rail(1'b1);
        chk(target_voltage_code_q, 8'hD3);
        host.access(1'b1, 8'h5F, 8'h02);
        rail(1'b0);
        host.access(1'b1, 8'h5F, 8'h03);
        rail(1'b1);
        host.access(1'b1, 8'h5F, 8'h00);
        rail(1'b0);
        seq_on = 1'b1;
        rail(1'b1);
        host.access(1'b1, 8'hDE, 8'h00);
        host.access(1'b1, 8'h5F, 8'h10);
        rail(1'b0);
        sleep_behaviour_register = 8'h00;
        rail(1'b1);
        // Mid-run reset: control back to zero, boot code reloaded
        rst = 1'b1;
        repeat (2) @(negedge sys_clk);
        chk({7'h00, rail_on_q}, 8'h00);
        rst = 1'b0;
        repeat (2) @(negedge sys_clk);
        rd(8'h5F, 8'h00);
        rd(8'hDE, 8'h00);
        rd(8'hDC, 8'h41);
        chk(boot_voltage_code_q, 8'h41);
        give_verdict();
    end
endmodule
